// *** rtl/hsms_pkg.sv ***
// hsms_pkg: constants and carrier types of the sampling/mode sequencer
// assumes a 100 MHz system clock and a 10 us internal conversion tick
package hsms_pkg;
  // system and internal clock periods
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_PERIOD_US  = 10;
  localparam int TICK_CYC        = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
  // micropower self-trigger rate, in internal ticks per sample
  localparam int MICRO_RATE_HZ   = 24;
  localparam int MICRO_TICKS     = 1000000 / (MICRO_RATE_HZ * TICK_PERIOD_US);
  // power-on settle time before the output is valid
  localparam int SETTLE_US       = 1000;
  localparam int SETTLE_CYC      = SETTLE_US * 1000 / CLK_PERIOD_NS;
  // conversion phases, in internal ticks
  localparam int DELAY_TICKS     = 1;
  localparam int AWAKE_TICKS     = 12;
  localparam int UPDATE_TICKS    = 1;
  localparam int EXT_CONV_TICKS  = 14;
  localparam int TURBO_CONV_TICKS = 16;
  // phase index positions within a conversion
  localparam logic [3:0] PH_AWAKE_FIRST = 4'h1;
  localparam logic [3:0] PH_AWAKE_LAST  = 4'hC;
  localparam logic [3:0] PH_UPDATE      = 4'hD;
  localparam logic [3:0] PH_DONE        = 4'hE;
  localparam logic [3:0] PH_IDLE        = 4'hF;
  // output code: 8 bits, zero field steps between 127 and 128
  localparam int         CODE_W   = 8;
  localparam logic [7:0] CODE_MID = 8'h80;
  // field sample: signed, 4 fraction bits per code step
  localparam int         FIELD_W  = 12;
  localparam int         FRAC_W   = 4;
  // a high level held this many ticks means turbo, not a pulse
  localparam int TURBO_HOLD_TICKS = 16;

  typedef enum logic [1:0] {
    HSMS_MICRO = 2'b00,
    HSMS_TURBO = 2'b01,
    HSMS_EXT   = 2'b10
  } hsms_mode_t;

  // status carried to the output stage
  typedef struct packed {
    logic [7:0] code;
    logic       valid;
    logic       awake;
    logic       busy;
    hsms_mode_t mode;
  } hsms_stat_t;
endpackage : hsms_pkg

// *** rtl/hsms_top.sv ***
// hsms_top: mode detection, conversion timing and output code register
// assumes field_in comes from the front end on clk; the mode pin is async
`timescale 1ns/100ps
`default_nettype none

// Operation
// - held-low control runs micropower mode, self-triggering at 24 Hz.
// - undriven control input reads low, giving micropower by default.
// - held-high control runs turbo, conversions of 16 ticks back to back.
// - a pulse train gives external-drive mode, one conversion per pulse.
// - external-drive conversion spans 14 internal ticks.
// - after a rising edge wait one 10 us tick, circuitry asleep.
// - then stay awake 12 ticks with measurement powered.
// - next tick loads the new code and puts circuitry to sleep.
// - output is invalid until the power-on settle time elapses.
// - zero field steps between codes 127 and 128.
// - converter and output code are 8 bits, 0 to 255.
// - south field raises the code, north field lowers it.
// - power-on settle time is about 1 ms.
module hsms_top #(
  parameter int MICRO_T  = hsms_pkg::MICRO_TICKS,
  parameter int SETTLE_C = hsms_pkg::SETTLE_CYC,
  parameter int TICK_C   = hsms_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // mode control pin: level and whether the host drives it
  input  wire logic                       mode_control_in,
  input  wire logic                       mode_control_drv,
  // field sample from the front end, signed, 4 fraction bits
  input  wire logic signed [11:0]         field_in,
  // sequencer status and output code
  output var hsms_pkg::hsms_stat_t        stat
);
  import hsms_pkg::*;

  // two-flop synchronisers for the pin
  logic [1:0] lvl_sy_r, drv_sy_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_sy_r <= 2'h0;
      drv_sy_r <= 2'h0;
    end else begin
      lvl_sy_r <= {lvl_sy_r[0], mode_control_in};
      drv_sy_r <= {drv_sy_r[0], mode_control_drv};
    end
  end

  // pull-down: a floating pin reads low
  logic lvl;
  assign lvl = lvl_sy_r[1] & drv_sy_r[1];

  // internal 10 us tick; a strobe on clk, so no second clock domain
  logic [15:0] div_r, div_nxt;
  logic        tick;
  assign tick = (div_r == 16'(TICK_C - 1));
  always_comb begin
    div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_r <= 16'h0000;
    else        div_r <= div_nxt;
  end

  // mode detection state
  logic       samp_r, samp_nxt;
  hsms_mode_t mode_r, mode_nxt;
  logic [5:0] hi_run_r, hi_run_nxt;
  logic [23:0] per_r, per_nxt;
  logic [3:0] ph_r, ph_nxt;
  logic       rise, fall, busy, start;

  // level is only looked at once per tick
  assign rise = tick & lvl & ~samp_r;
  assign fall = tick & ~lvl & samp_r;
  assign busy = (ph_r < PH_DONE);

  // start of a conversion, by mode; the self-timed start follows mode_nxt
  // so that leaving another mode does not stretch the period by a tick
  always_comb begin
    start = 1'b0;
    if (tick) begin
      if (rise && !busy)
        start = 1'b1;
      else if (mode_r == HSMS_TURBO && lvl && ph_r == PH_IDLE)
        start = 1'b1;
      else if (mode_nxt == HSMS_MICRO && per_r >= 24'(MICRO_T - 1))
        start = 1'b1;
    end
  end

  // next mode: falling edge after a pulse means external drive
  always_comb begin
    samp_nxt   = samp_r;
    mode_nxt   = mode_r;
    hi_run_nxt = hi_run_r;
    if (tick) begin
      samp_nxt = lvl;
      if (!lvl)
        hi_run_nxt = 6'h00;
      else if (hi_run_r != 6'h3F)
        hi_run_nxt = hi_run_r + 6'h01;
      if (fall)
        mode_nxt = HSMS_EXT;
      else if (lvl && hi_run_r >= 6'(TURBO_HOLD_TICKS - 1))
        mode_nxt = HSMS_TURBO;
      else if (!lvl && mode_r != HSMS_MICRO
               && per_r >= 24'(MICRO_T - 1))
        mode_nxt = HSMS_MICRO;
    end
  end

  // phase and period counters; phase saturates at idle
  always_comb begin
    ph_nxt  = ph_r;
    per_nxt = per_r;
    if (tick) begin
      if (start) begin
        ph_nxt  = 4'h0;
        per_nxt = 24'h000000;
      end else begin
        if (ph_r != PH_IDLE) ph_nxt = ph_r + 4'h1;
        if (per_r != 24'hFFFFFF) per_nxt = per_r + 24'h000001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_r   <= 1'b0;
      mode_r   <= HSMS_MICRO;
      hi_run_r <= 6'h00;
      ph_r     <= PH_IDLE;
      per_r    <= 24'h000000;
    end else begin
      samp_r   <= samp_nxt;
      mode_r   <= mode_nxt;
      hi_run_r <= hi_run_nxt;
      ph_r     <= ph_nxt;
      per_r    <= per_nxt;
    end
  end

  // awake: phases 1..12, asleep in the delay tick and after
  logic awake;
  assign awake = (ph_r >= PH_AWAKE_FIRST) && (ph_r <= PH_AWAKE_LAST);

  // capture at end of awake, load into the output in the update tick
  logic [7:0] cap_r, cap_nxt, code_r, code_nxt;
  always_comb begin
    cap_nxt  = cap_r;
    code_nxt = code_r;
    // integer part offset by mid-scale; 0+ maps to 128, 0- to 127
    if (tick && ph_r == PH_AWAKE_LAST)
      cap_nxt = 8'(field_in[FIELD_W-1:FRAC_W]) + CODE_MID;
    if (tick && ph_r == PH_UPDATE)
      code_nxt = cap_r;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_r  <= CODE_MID;
      code_r <= CODE_MID;
    end else begin
      cap_r  <= cap_nxt;
      code_r <= code_nxt;
    end
  end

  // power-on settle counter; reset stands in for power-up
  logic [23:0] por_r, por_nxt;
  logic        valid_r, valid_nxt;
  always_comb begin
    por_nxt   = por_r;
    valid_nxt = valid_r;
    if (por_r != 24'(SETTLE_C - 1))
      por_nxt = por_r + 24'h000001;
    else
      valid_nxt = 1'b1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_r   <= 24'h000000;
      valid_r <= 1'b0;
    end else begin
      por_r   <= por_nxt;
      valid_r <= valid_nxt;
    end
  end

  // one driver for the whole status word
  assign stat = '{code: code_r, valid: valid_r, awake: awake, busy: busy,
                  mode: mode_r};

  // helper counters for checks
  logic [23:0] awk_cyc_r, st_cyc_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awk_cyc_r <= 24'h000000;
      st_cyc_r  <= 24'h000000;
    end else begin
      awk_cyc_r <= awake ? awk_cyc_r + 24'h000001 : 24'h000000;
      st_cyc_r  <= start ? 24'h000000 : st_cyc_r + 24'h000001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_update;
    tick && ph_r == PH_UPDATE;
  endsequence
  sequence s_load;
    ##1 code_r == $past(cap_r);
  endsequence

  a_delay_asleep: assert property (
    $rose(awake) |-> st_cyc_r == 24'(TICK_C))
    else $error("awake began without one tick of delay");
  a_awake_len: assert property (
    $fell(awake) |-> $past(awk_cyc_r) == 24'(AWAKE_TICKS * TICK_C - 1))
    else $error("awake phase length wrong");
  a_update_load: assert property (
    s_update |-> s_load ##0 !awake)
    else $error("code not loaded in update tick");
  a_code_hold: assert property (
    !(tick && ph_r == PH_UPDATE) |=> $stable(code_r))
    else $error("code changed outside update");
  a_ext_len: assert property (
    tick && ph_r == PH_UPDATE && !start |=> !busy)
    else $error("conversion not done after 14 ticks");
  a_turbo_rate: assert property (
    start && mode_r == HSMS_TURBO && !rise |-> ph_r == PH_IDLE)
    else $error("turbo restart off period");
  a_micro_rate: assert property (
    start && mode_r == HSMS_MICRO && !rise
      |-> per_r == 24'(MICRO_T - 1))
    else $error("micropower restart off period");
  a_ext_enter: assert property (
    fall |=> mode_r == HSMS_EXT)
    else $error("falling edge did not select external drive");
  a_pull_down: assert property (
    !drv_sy_r[1] |-> !lvl)
    else $error("floating pin not read as low");
  a_settle_valid: assert property (
    $rose(valid_r) |-> por_r == 24'(SETTLE_C - 1))
    else $error("output valid before settle time");
  a_zero_step: assert property (
    tick && ph_r == PH_AWAKE_LAST && field_in[FIELD_W-1:FRAC_W] == 8'h00
      |=> cap_r == CODE_MID)
    else $error("zero-plus field not mid-scale");

  // each conversion opens with one asleep delay tick
  sequence s_delay_tick;
    ph_r == 4'h0 && !awake;
  endsequence

  a_start_delay: assert property (
    start |=> s_delay_tick)
    else $error("conversion did not open with a delay tick");
  a_no_overlap: assert property (
    start |-> !busy)
    else $error("conversion started while one was running");
  a_rise_start: assert property (
    rise && !busy |-> start)
    else $error("idle rising edge did not start a conversion");
  a_update_sleep: assert property (
    ph_r == PH_UPDATE |-> !awake && busy)
    else $error("circuitry awake in the update tick");
  a_idle_sleep: assert property (
    !busy |-> !awake)
    else $error("circuitry awake outside a conversion");
  a_rise_sampled: assert property (
    tick |=> samp_r == $past(lvl))
    else $error("pin level not sampled on the tick");

  // mode entry and restart spacing, counted in system cycles
  a_turbo_enter: assert property (
    tick && lvl && hi_run_r >= 6'(TURBO_HOLD_TICKS - 1)
      |=> mode_r == HSMS_TURBO)
    else $error("long high level did not select turbo");
  a_turbo_gap: assert property (
    start && mode_r == HSMS_TURBO
      |-> st_cyc_r >= 24'(TURBO_CONV_TICKS * TICK_C - 1))
    else $error("turbo restart sooner than one conversion period");
  a_micro_return: assert property (
    tick && !lvl && !fall && mode_r != HSMS_MICRO
      && per_r >= 24'(MICRO_T - 1) |=> mode_r == HSMS_MICRO)
    else $error("quiet low pin did not return to micropower");
  a_micro_gap: assert property (
    start && mode_r == HSMS_MICRO && !rise
      |-> st_cyc_r == 24'(MICRO_T * TICK_C - 1))
    else $error("micropower restart off the self-timed period");
  a_valid_stays: assert property (
    valid_r |=> valid_r)
    else $error("output valid dropped after settling");
endmodule : hsms_top

`default_nettype wire

// *** test/hsms_host_model.sv ***
// hsms_host_model: host that ties, floats or pulses the mode control pin
// assumes bench requests change just after a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module hsms_host_model #(
  parameter int PULSE_CYC = 16
) (
  // clock
  input  wire logic clk,
  // requests from the bench
  input  wire logic drv_req,
  input  wire logic hi_req,
  input  wire logic pulse_go,
  // mode control pin
  output logic      mode_control_in,
  output logic      mode_control_drv
);
  int cnt_r = 0;

  // start pulse held well past the minimum width, never a short glitch
  always @(posedge clk) begin
    if (pulse_go) begin
      cnt_r <= PULSE_CYC;
    end else if (cnt_r > 0) begin
      cnt_r <= cnt_r - 1;
    end
  end

  // a released pin falls to the pull-down level, not the last value
  assign mode_control_drv = drv_req;
  assign mode_control_in  = drv_req & (hi_req | (cnt_r > 0));
endmodule : hsms_host_model
`default_nettype wire

// *** test/hall_sample_mode_sequencer_bench.sv ***
// hall_sample_mode_sequencer_bench: self-checking bench of hsms_top
// assumes shortened counts: 4 clk per tick, 50 ticks micro, 200 settle
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; \
  if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module hall_sample_mode_sequencer_bench;
  import hsms_pkg::*;
  localparam int TC = 4;
  localparam int MT = 50;
  localparam int SC = 200;
  logic               clk      = 1'b0;
  logic               rst_n    = 1'b0;
  logic               drv_req  = 1'b0;
  logic               hi_req   = 1'b0;
  logic               pulse_go = 1'b0;
  logic signed [11:0] field_in = 12'sh000;
  logic               mode_control_in;
  logic               mode_control_drv;
  hsms_stat_t         stat;
  int                 fails = 0;
  int                 total_checks = 0;
  logic [11:0]        tbl [5] = '{12'h000, 12'hFFF, 12'h010, 12'h7FF, 12'h800};

  always #5 clk = ~clk;

  hsms_top #(.MICRO_T(MT), .SETTLE_C(SC), .TICK_C(TC)) hsms_top_inst (
    .clk(clk), .rst_n(rst_n), .mode_control_in(mode_control_in),
    .mode_control_drv(mode_control_drv), .field_in(field_in), .stat(stat));

  hsms_host_model hsms_host_model_inst (
    .clk(clk), .drv_req(drv_req), .hi_req(hi_req), .pulse_go(pulse_go),
    .mode_control_in(mode_control_in), .mode_control_drv(mode_control_drv));

  task automatic results;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // bounded wait on busy (sel 0) or awake (sel 1), counting falling edges
  task automatic wait_for(input int sel, input logic lvl, input int lim,
                          output int cnt);
    cnt = 0;
    while ((sel ? stat.awake : stat.busy) !== lvl) begin
      @(negedge clk);
      cnt++;
      if (cnt > lim) begin
        fails++;
        $display("[FAIL] wait exp %0d got timeout", lim);
        results();
      end
    end
  endtask : wait_for

  // reset values, then valid rising only after the settle count
  task automatic power_on;
    `CHK("code", 8'h80, stat.code)
    `CHK("valid", 1'b0, stat.valid)
    `CHK("mode", HSMS_MICRO, stat.mode)
    repeat (SC - 10) @(negedge clk);
    `CHK("valid early", 1'b0, stat.valid)
    repeat (12) @(negedge clk);
    `CHK("valid", 1'b1, stat.valid)
  endtask : power_on

  // one external pulse: delay, awake, update timing and the new code
  task automatic ext_conv(input logic [11:0] f);
    logic [7:0] old;
    logic [7:0] exp;
    int         d;
    int         a;
    int         u;
    wait_for(0, 1'b0, 300, d);
    old = stat.code;
    exp = f[11:4] + 8'h80;
    field_in = f;
    pulse_go = 1'b1;
    @(negedge clk);
    pulse_go = 1'b0;
    wait_for(0, 1'b1, 40, d);
    wait_for(1, 1'b1, 10, d);
    `CHK("delay", DELAY_TICKS * TC, d)
    wait_for(1, 1'b0, 60, a);
    `CHK("awake", AWAKE_TICKS * TC, a)
    `CHK("hold", old, stat.code)
    wait_for(0, 1'b0, 10, u);
    `CHK("update", UPDATE_TICKS * TC, u)
    `CHK("conv", EXT_CONV_TICKS * TC, d + a + u)
    `CHK("code", exp, stat.code)
    `CHK("mode", HSMS_EXT, stat.mode)
  endtask : ext_conv

  // held high: back-to-back conversions at the turbo period
  task automatic turbo_run;
    int n;
    int m;
    hi_req = 1'b1;
    repeat (5) begin
      wait_for(0, 1'b0, 100, n);
      wait_for(0, 1'b1, 100, m);
    end
    `CHK("turbo period", TURBO_CONV_TICKS * TC, n + m)
    `CHK("mode", HSMS_TURBO, stat.mode)
    hi_req = 1'b0;
  endtask : turbo_run

  // floating pin: falls back to self-timed micropower sampling
  task automatic micro_run;
    int n;
    int m;
    drv_req = 1'b0;
    repeat (3) begin
      wait_for(0, 1'b0, 300, n);
      wait_for(0, 1'b1, 300, m);
    end
    `CHK("micro period", MT * TC, n + m)
    `CHK("mode", HSMS_MICRO, stat.mode)
    `CHK("valid", 1'b1, stat.valid)
  endtask : micro_run

  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    power_on();
    drv_req = 1'b1;
    foreach (tbl[i]) ext_conv(tbl[i]);
    turbo_run();
    micro_run();
    results();
  end
endmodule : hall_sample_mode_sequencer_bench
`default_nettype wire
